// ===== core/ddtc_top.sv
// descriptor data transfer controller: descriptor fetch, transfer, write-back
// assumes ram answers one cycle after a request and the data bus acks with bus_ack
`default_nettype none
// Summary of operation
// - source pointer fixed, incremented or decremented
// - destination pointer fixed, incremented or decremented
// - byte or word units, step 1 or 2
// - kind codes: normal, repeat, block
// - area side selects destination or source
// - chained transfer skips end decision and clears
// - interrupt per transfer or at count end
// - chain always, or only at counter zero
// - low five mode b bits ignored
// - normal mode: 16-bit count to zero
// - running byte reloads from reload byte
// - block count decremented per block, ends zero
// - repeat restores area pointer and count
// - block mode moves whole block per activation
// - normal and repeat move one unit
// - load descriptor, transfer, write back
// - fixed pointers are not written back
// - 32-bit ram word in one state
// - enabled source goes to controller, else cpu
// - end or per-transfer interrupt clears enable, else clears source flag
// - descriptor order fixed, chains consecutive
module ddtc_top
  import ddtc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [NSRC-1:0] src_flag,
  input wire logic en_we,
  input wire logic [NSRC-1:0] en_wdata,
  output logic [NSRC-1:0] en_q,
  output logic [NSRC-1:0] flag_clr_q,
  output logic [NSRC-1:0] cpu_irq_q,
  output logic busy_q,
  output logic ram_req_q,
  output logic ram_we_q,
  output logic [23:0] ram_addr_q,
  output logic [31:0] ram_wdata_q,
  input wire logic [31:0] ram_rdata,
  output logic bus_req_q,
  output logic bus_we_q,
  output logic bus_word_q,
  output logic [23:0] bus_addr_q,
  output logic [15:0] bus_wdata_q,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack
);

  ddtc_state_t st_q, st_d;
  logic [2:0] idx_q;
  logic [23:0] desc_q, desc_d, src_q, dst_q, src_n, dst_n;
  logic [7:0] mode_a_q, mode_b_q;
  logic [15:0] cra_q, crb_q;
  logic end_q, zero_q, upd, unit_last, chain_go;
  logic [NSRC-1:0] pend;

  // one unit step of a pointer
  function automatic logic [23:0] ptr_step(input logic [23:0] a, input logic [1:0] m,
                                           input logic sz);
    logic [23:0] st;
    st = sz ? 24'h000002 : 24'h000001;
    ptr_step = !m[1] ? a : (m[0] ? a - st : a + st);
  endfunction : ptr_step
  // undo a whole area of steps, 0 in reload byte means 256 units
  function automatic logic [23:0] ptr_rewind(input logic [23:0] a, input logic [1:0] m,
                                             input logic sz, input logic [7:0] n);
    logic [23:0] span;
    span = {15'h0000, (n == 8'h00), n} << sz;
    ptr_rewind = !m[1] ? a : (m[0] ? a + span : a - span);
  endfunction : ptr_rewind

  // lowest numbered pending source wins
  function automatic logic [2:0] pick(input logic [NSRC-1:0] p);
    pick = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--)
      if (p[i])
        pick = 3'(i);
  endfunction : pick

  wire [1:0] kind = mode_a_q[KIND_HI:KIND_LO];
  wire [1:0] smode = mode_a_q[SRC_MODE_HI:SRC_MODE_LO];
  wire [1:0] dmode = mode_a_q[DST_MODE_HI:DST_MODE_LO];
  wire sz = mode_a_q[UNIT_SIZE];
  wire [7:0] reload = cra_q[15:8];
  wire [7:0] running = cra_q[7:0];
  // only enabled sources reach the controller
  assign pend = src_flag & en_q;
  assign upd = (st_q == ST_XWR) && bus_ack;
  assign unit_last = (kind == KIND_NORMAL) ? (cra_q == 16'h0001) : (running == 8'h01);
  // chaining may follow every transfer or only the zero count
  assign chain_go = mode_b_q[CHAIN_EN] && (!mode_b_q[CHAIN_COND] || zero_q);
  // next descriptor base; the first word read is launched before desc_q catches up
  assign desc_d = (st_q == ST_VECW) ? ram_rdata[23:0] :
                  (st_q == ST_WBC && chain_go) ? desc_q + DESC_STRIDE : desc_q;

  // pointer values after the current unit, with area rewind
  always_comb
  begin
    src_n = src_q;
    dst_n = dst_q;
    if (upd)
    begin
      src_n = ptr_step(src_q, smode, sz);
      dst_n = ptr_step(dst_q, dmode, sz);
      if (kind != KIND_NORMAL && unit_last)
      begin
        if (mode_a_q[AREA_SIDE])
          src_n = ptr_rewind(src_n, smode, sz, reload);
        else
          dst_n = ptr_rewind(dst_n, dmode, sz, reload);
      end
    end
  end

  // sequencer
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: if (|pend) st_d = ST_VEC;
      ST_VEC: st_d = ST_VECW;
      ST_VECW: st_d = ST_RDA;
      ST_RDA: st_d = ST_RDB;
      ST_RDB: st_d = ST_RDC;
      ST_RDC: st_d = ST_RDD;
      ST_RDD: st_d = ST_XRD;
      ST_XRD: if (bus_ack) st_d = ST_XWR;
      ST_XWR:
        if (bus_ack)
          // a block runs to its last unit in one activation
          st_d = (kind == KIND_BLOCK && !unit_last) ? ST_XRD : ST_WBA;
      ST_WBA: st_d = ST_WBB;
      ST_WBB: st_d = ST_WBC;
      ST_WBC: st_d = chain_go ? ST_RDA : ST_FIN;
      ST_FIN: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_q <= ST_IDLE;
    else
      st_q <= st_d;
  end

  // source capture and descriptor pointer; chains sit back to back
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      idx_q <= 3'h0;
      desc_q <= 24'h000000;
    end
    else
    begin
      if (st_q == ST_IDLE)
        idx_q <= pick(pend);
      desc_q <= desc_d;
    end
  end

  // working registers: loaded from ram, stepped per unit
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_a_q <= 8'h00;
      mode_b_q <= 8'h00;
      src_q <= 24'h000000;
      dst_q <= 24'h000000;
      cra_q <= 16'h0000;
      crb_q <= 16'h0000;
    end
    else
    begin
      unique case (st_q)
        ST_RDB: {mode_a_q, src_q} <= ram_rdata;
        ST_RDC: {mode_b_q, dst_q} <= ram_rdata;
        ST_RDD: {cra_q, crb_q} <= ram_rdata;
        default:
        begin
          src_q <= src_n;
          dst_q <= dst_n;
        end
      endcase
      if (upd && kind == KIND_NORMAL)
        cra_q <= cra_q - 16'h0001;
      else if (upd)
        cra_q[7:0] <= unit_last ? reload : running - 8'h01;
      if (upd && kind == KIND_BLOCK && unit_last)
        crb_q <= crb_q - 16'h0001;
    end
  end

  // end and zero flags of the activation
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      end_q <= 1'b0;
      zero_q <= 1'b0;
    end
    else if (st_q == ST_RDD || upd)
    begin
      zero_q <= upd && unit_last;
      // repeat never runs out, block ends on its last block
      end_q <= upd && unit_last && (kind == KIND_NORMAL ||
               (kind == KIND_BLOCK && crb_q == 16'h0001));
    end
  end

  // ram port, registered from the next state
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ram_req_q <= 1'b0;
      ram_we_q <= 1'b0;
      ram_addr_q <= 24'h000000;
      ram_wdata_q <= 32'h00000000;
    end
    else
    begin
      ram_req_q <= 1'b0;
      ram_we_q <= 1'b0;
      unique case (st_d)
        ST_VEC:
        begin
          ram_req_q <= 1'b1;
          ram_addr_q <= VEC_BASE + {19'h00000, pick(pend), 2'h0}; // idx_q not yet captured
        end
        ST_RDA, ST_RDB, ST_RDC:
        begin
          ram_req_q <= 1'b1;
          ram_addr_q <= desc_d + ((st_d == ST_RDA) ? OFS_W0 : (st_d == ST_RDB) ? OFS_W1 : OFS_W2);
        end
        ST_WBA:
        begin
          ram_req_q <= smode[1];
          ram_we_q <= smode[1];
          ram_addr_q <= desc_q + OFS_W0;
          ram_wdata_q <= {mode_a_q, src_n};
        end
        ST_WBB:
        begin
          ram_req_q <= dmode[1];
          ram_we_q <= dmode[1];
          ram_addr_q <= desc_q + OFS_W1;
          ram_wdata_q <= {mode_b_q, dst_q};
        end
        ST_WBC:
        begin
          ram_req_q <= 1'b1;
          ram_we_q <= 1'b1;
          ram_addr_q <= desc_q + OFS_W2;
          ram_wdata_q <= {cra_q, crb_q};
        end
        default: ram_req_q <= 1'b0;
      endcase
    end
  end

  // data bus: read at source, write at destination
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_req_q <= 1'b0;
      bus_we_q <= 1'b0;
      bus_word_q <= 1'b0;
      bus_addr_q <= 24'h000000;
      bus_wdata_q <= 16'h0000;
    end
    else
    begin
      bus_req_q <= (st_d == ST_XRD) || (st_d == ST_XWR);
      bus_we_q <= (st_d == ST_XWR);
      bus_word_q <= sz; // mode a is loaded two states before the first read
      bus_addr_q <= (st_d == ST_XWR) ? dst_n : src_n;
      if (st_q == ST_XRD && bus_ack)
        bus_wdata_q <= bus_rdata;
    end
  end

  // enable bank and source flag handling at the end of an activation
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      en_q <= EN_RESET;
      flag_clr_q <= '0;
    end
    else
    begin
      flag_clr_q <= '0;
      if (en_we)
        en_q <= en_wdata;
      if (st_q == ST_WBC && !mode_b_q[CHAIN_EN])
      begin
        if (mode_b_q[PER_XFER_IRQ] || end_q)
          en_q[idx_q] <= 1'b0;
        else
          flag_clr_q[idx_q] <= 1'b1;
      end
    end
  end

  // sources with enable clear are passed to the cpu
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cpu_irq_q <= '0;
      busy_q <= 1'b0;
    end
    else
    begin
      cpu_irq_q <= src_flag & ~en_q;
      busy_q <= (st_d != ST_IDLE);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  src_fixed_a: assert property ((upd && !smode[1]) |=> src_q == $past(src_q))
    else $error("fixed source pointer moved");
  src_step_a: assert property ((upd && kind == KIND_NORMAL && smode == 2'h2)
    |=> src_q == $past(src_q) + (sz ? 24'h000002 : 24'h000001))
    else $error("source pointer step wrong");
  dst_dec_a: assert property ((upd && dmode == 2'h3 &&
    (kind == KIND_NORMAL || mode_a_q[AREA_SIDE]))
    |=> dst_q == $past(dst_q) - (sz ? 24'h000002 : 24'h000001))
    else $error("destination pointer decrement wrong");
  norm_count_a: assert property ((upd && kind == KIND_NORMAL)
    |=> cra_q == $past(cra_q) - 16'h0001)
    else $error("normal count not decremented");
  byte_reload_a: assert property ((upd && kind != KIND_NORMAL && running == 8'h01)
    |=> cra_q[7:0] == cra_q[15:8])
    else $error("running byte not reloaded");
  block_loop_a: assert property ((upd && kind == KIND_BLOCK && running != 8'h01)
    |=> st_q == ST_XRD)
    else $error("block stopped early");
  ram_single_a: assert property ((st_q == ST_RDB || st_q == ST_RDC)
    |-> ram_req_q && !ram_we_q && ram_addr_q == $past(ram_addr_q) + 24'h000004)
    else $error("descriptor read not one word per state");
  wb_skip_a: assert property ((st_q == ST_WBA && !smode[1]) |-> !ram_we_q)
    else $error("fixed source pointer written back");
  chain_keep_a: assert property ((st_q == ST_WBC && mode_b_q[CHAIN_EN])
    |=> flag_clr_q == '0 && en_q == $past(en_q) || $past(en_we))
    else $error("chained transfer cleared source state");
  single_unit_a: assert property ((upd && kind != KIND_BLOCK) |=> st_q == ST_WBA)
    else $error("extra unit moved");
  norm_c: cover property (upd && kind == KIND_NORMAL && unit_last);
  block_c: cover property (upd && kind == KIND_BLOCK && unit_last);
  chain_c: cover property (st_q == ST_WBC && chain_go);
endmodule : ddtc_top
`default_nettype wire

// ===== core/ddtc_pkg.sv
// constants for the descriptor data transfer controller
// assumes one clock, 8 interrupt sources and a 32-bit on-chip ram port
`default_nettype none
package ddtc_pkg;
  localparam int NSRC = 8;
  // descriptor layout in ram: three aligned words per descriptor
  localparam logic [23:0] VEC_BASE = 24'h000400; // vector table, one word per source
  localparam logic [23:0] OFS_W0 = 24'h000000; // mode a + source pointer
  localparam logic [23:0] OFS_W1 = 24'h000004; // mode b + destination pointer
  localparam logic [23:0] OFS_W2 = 24'h000008; // count a + block count
  localparam logic [23:0] DESC_STRIDE = 24'h00000C;
  // transfer_mode_a fields
  localparam int SRC_MODE_HI = 7;
  localparam int SRC_MODE_LO = 6;
  localparam int DST_MODE_HI = 5;
  localparam int DST_MODE_LO = 4;
  localparam int KIND_HI = 3;
  localparam int KIND_LO = 2;
  localparam int AREA_SIDE = 1;
  localparam int UNIT_SIZE = 0;
  // transfer_mode_b fields, bits 4..0 ignored
  localparam int CHAIN_EN = 7;
  localparam int PER_XFER_IRQ = 6;
  localparam int CHAIN_COND = 5;
  localparam logic [1:0] KIND_NORMAL = 2'h0;
  localparam logic [1:0] KIND_REPEAT = 2'h1;
  localparam logic [1:0] KIND_BLOCK = 2'h2;
  localparam logic [NSRC-1:0] EN_RESET = 8'h00;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_VEC = 4'h1, ST_VECW = 4'h3, ST_RDA = 4'h2,
    ST_RDB = 4'h6, ST_RDC = 4'h7, ST_RDD = 4'h5, ST_XRD = 4'h4,
    ST_XWR = 4'hC, ST_WBA = 4'hD, ST_WBB = 4'hF, ST_WBC = 4'hE,
    ST_FIN = 4'hA
  } ddtc_state_t;
endpackage : ddtc_pkg
`default_nettype wire

// ===== tb/ddtc_mem_model.sv
// partner model: 32-bit descriptor ram and a byte-wide data memory
// assumes the ram and data bus ports of ddtc_top on one clock
`default_nettype none
module ddtc_mem_model (
  input wire logic clk,
  input wire logic ram_req_q,
  input wire logic ram_we_q,
  input wire logic [23:0] ram_addr_q,
  input wire logic [31:0] ram_wdata_q,
  output logic [31:0] ram_rdata,
  input wire logic bus_req_q,
  input wire logic bus_we_q,
  input wire logic bus_word_q,
  input wire logic [23:0] bus_addr_q,
  input wire logic [15:0] bus_wdata_q,
  output logic [15:0] bus_rdata,
  output logic bus_ack,
  input wire logic [3:0] dly
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ram [0:1023];
  logic [7:0] dmem [0:255];
  logic [3:0] cnt;
  logic go;
  logic [7:0] a;
  // known data pattern so moved bytes can be traced
  initial
  begin
    ram_rdata = 32'h0;
    bus_rdata = 16'h0;
    bus_ack = 1'b0;
    cnt = 4'h0;
    for (int i = 0; i < 256; i++)
      dmem[i] = 8'(i) ^ 8'h5A;
  end
  // whole word per state; stale data inverted so it never looks valid
  always @(posedge clk)
  begin
    if (ram_req_q && ram_we_q)
      ram[ram_addr_q[11:2]] <= ram_wdata_q;
    ram_rdata <= (ram_req_q && !ram_we_q) ? ram[ram_addr_q[11:2]] : ~ram_rdata;
  end
  assign go = bus_req_q && !bus_ack && (cnt >= dly);
  assign a = bus_addr_q[7:0];
  // ack after dly wait cycles; a new request restarts the wait
  always @(posedge clk)
  begin
    cnt <= (bus_req_q && !bus_ack) ? cnt + 4'h1 : 4'h0;
    bus_ack <= go;
    bus_rdata <= ~bus_rdata;
    if (go && !bus_we_q)
      bus_rdata <= bus_word_q ? {dmem[a], dmem[a + 8'h1]} : {8'h00, dmem[a]};
    if (go && bus_we_q && bus_word_q)
    begin
      dmem[a] <= bus_wdata_q[15:8];
      dmem[a + 8'h1] <= bus_wdata_q[7:0];
    end
    if (go && bus_we_q && !bus_word_q)
      dmem[a] <= bus_wdata_q[7:0];
  end
endmodule : ddtc_mem_model
`default_nettype wire

// ===== tb/descriptor_data_transfer_controller_test.sv
// self-checking bench: descriptors in ram, one activation source driven
// assumes ddtc_top and ddtc_mem_model; source 0 vector points at 24'h000100
`default_nettype none
module descriptor_data_transfer_controller_test
  import ddtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [NSRC-1:0] src_flag = '0;
  logic en_we = 1'b0;
  logic [NSRC-1:0] en_wdata = '0;
  logic [3:0] dly = 4'h0;
  logic [NSRC-1:0] en_q, flag_clr_q, cpu_irq_q, clr_seen = '0;
  logic busy_q, ram_req_q, ram_we_q, bus_req_q, bus_we_q, bus_word_q, bus_ack;
  logic [23:0] ram_addr_q, bus_addr_q;
  logic [31:0] ram_wdata_q, ram_rdata;
  logic [15:0] bus_wdata_q, bus_rdata;
  int n_fail = 0;
  int n_compared = 0;
  int n_wb = 0;
  ddtc_top dut (.clk, .arst_n, .src_flag, .en_we, .en_wdata, .en_q, .flag_clr_q,
    .cpu_irq_q, .busy_q, .ram_req_q, .ram_we_q, .ram_addr_q, .ram_wdata_q, .ram_rdata,
    .bus_req_q, .bus_we_q, .bus_word_q, .bus_addr_q, .bus_wdata_q, .bus_rdata, .bus_ack);
  ddtc_mem_model mem (.clk, .ram_req_q, .ram_we_q, .ram_addr_q, .ram_wdata_q, .ram_rdata,
    .bus_req_q, .bus_we_q, .bus_word_q, .bus_addr_q, .bus_wdata_q, .bus_rdata, .bus_ack,
    .dly);
  always #5 clk = ~clk;
  // source side drops its flag on request; destination write-backs counted
  always @(posedge clk)
  begin
    // only on a pulse, so the reset of clr_seen in fire never races this
    if (|flag_clr_q)
      clr_seen <= clr_seen | flag_clr_q;
    if (|flag_clr_q)
      src_flag <= src_flag & ~flag_clr_q;
    if (ram_req_q && ram_we_q && ram_addr_q == 24'h000104)
      n_wb <= n_wb + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    if (seen !== exp)
      n_fail++;
  endtask : chk
  task automatic complete_run;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // descriptor: any 24-bit pointers, odd ones too, three words in fixed order
  task automatic put(input logic [23:0] a, input logic [7:0] ma, input logic [23:0] s,
    input logic [7:0] mb, input logic [23:0] d, input logic [31:0] cnts);
    mem.ram[a[11:2]] = {ma, s};
    mem.ram[a[11:2] + 10'h1] = {mb, d};
    mem.ram[a[11:2] + 10'h2] = cnts;
  endtask : put
  function automatic logic [31:0] rw(input logic [23:0] a);
    return mem.ram[a[11:2]];
  endfunction : rw
  // enable source 0, raise its flag, wait for the sequencer to go idle
  task automatic fire;
    int k;
    en_we <= 1'b1;
    en_wdata <= 8'h01;
    @(posedge clk);
    en_we <= 1'b0;
    src_flag <= 8'h01;
    clr_seen <= '0;
    n_wb <= 0;
    // busy is looked at mid-cycle, away from the edge that updates it
    for (k = 0; k < 50 && !busy_q; k++)
      @(negedge clk);
    for (k = 0; k < 900 && busy_q; k++)
      @(negedge clk);
    chk(busy_q, 1'b0);
    repeat (2) @(posedge clk);
  endtask : fire
  initial
  begin
    mem.ram[10'h100] = 32'h00000100;
    repeat (5) @(posedge clk);
    chk(en_q, 8'h00);
    arst_n <= 1'b1;
    @(posedge clk);
    // normal byte, both pointers step up, ignored mode b bits set
    put(24'h000100, 8'hA0, 24'h000020, 8'h1F, 24'h000080, 32'h00020000);
    fire();
    chk(rw(24'h000100), 32'hA0000021);
    chk(rw(24'h000104), 32'h1F000081);
    chk(rw(24'h000108), 32'h00010000);
    chk(mem.dmem[8'h80], 8'h20 ^ 8'h5A);
    chk({en_q[0], clr_seen[0]}, 2'h3);
    fire();
    chk(rw(24'h000108), 32'h00000000);
    chk({en_q[0], cpu_irq_q[0]}, 2'h1);
    // word, source steps down, fixed destination, interrupt per transfer
    dly <= 4'h2;
    put(24'h000100, 8'hC1, 24'h000030, 8'h40, 24'h000090, 32'h00050000);
    fire();
    chk(rw(24'h000100), 32'hC100002E);
    chk(n_wb, 0);
    chk(rw(24'h000108), 32'h00040000);
    chk({mem.dmem[8'h90], mem.dmem[8'h91]}, 16'h6A6B);
    chk(en_q[0], 1'b0);
    // block of two bytes, destination is the block area, slow bus
    dly <= 4'h3;
    put(24'h000100, 8'hA8, 24'h000040, 8'h00, 24'h0000A0, 32'h02020001);
    fire();
    chk(rw(24'h000100), 32'hA8000042);
    chk(rw(24'h000104), 32'h000000A0);
    chk(rw(24'h000108), 32'h02020000);
    chk(mem.dmem[8'hA1], 8'h41 ^ 8'h5A);
    chk(en_q[0], 1'b0);
    // repeat, source is the area, destination steps down
    dly <= 4'h0;
    put(24'h000100, 8'hB6, 24'h000050, 8'h00, 24'h0000B0, 32'h01010000);
    fire();
    chk(rw(24'h000100), 32'hB6000050);
    chk(rw(24'h000104), 32'h000000AF);
    chk(rw(24'h000108), 32'h01010000);
    chk(mem.dmem[8'hB0], 8'h50 ^ 8'h5A);
    chk({en_q[0], clr_seen[0]}, 2'h3);
    // chain every time into the next consecutive descriptor
    put(24'h000100, 8'hA0, 24'h000060, 8'h80, 24'h0000C0, 32'h00050000);
    put(24'h00010C, 8'hA0, 24'h000061, 8'h00, 24'h0000C1, 32'h00010000);
    fire();
    chk(rw(24'h000108), 32'h00040000);
    chk(rw(24'h000114), 32'h00000000);
    chk({mem.dmem[8'hC0], mem.dmem[8'hC1]}, 16'h3A3B);
    chk(en_q[0], 1'b0);
    // chain only at zero: first activation stops, the retrigger chains on
    put(24'h000100, 8'hA0, 24'h000070, 8'hA0, 24'h0000D0, 32'h00020000);
    put(24'h00010C, 8'hA0, 24'h000072, 8'h00, 24'h0000D2, 32'h00010000);
    fire();
    repeat (40) @(posedge clk);
    chk(rw(24'h000108), 32'h00000000);
    chk(rw(24'h000114), 32'h00000000);
    chk({mem.dmem[8'hD1], mem.dmem[8'hD2]}, 16'h2B28);
    chk(en_q[0], 1'b0);
    complete_run();
  end
  // a hang counts as a mismatch and ends the run the normal way
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule : descriptor_data_transfer_controller_test
`default_nettype wire
